// *** src/dbp_protect.sv ***
// Drive and battery protection: speed trip, voltage cutback and cut-out,
// charge gauge, battery current limiting. Assumes synchronous measurements.
`default_nettype none
module dbp_protect #(
    parameter int LOOP_CYCLES = dbp_pkg::LOOP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Measurements and external inputs
    input wire dbp_pkg::dbp_meas_t meas,
    input wire dbp_pkg::dbp_lim_t bms_lim,
    input wire logic profile_active,
    input wire logic signed [15:0] torque_req,
    // Protection outputs
    output logic power_enable,
    output logic brake_request,
    output logic [7:0] regen_scale,
    output logic [7:0] drive_scale,
    output logic low_battery_profile,
    output logic low_charge_warn,
    output logic [6:0] charge_gauge,
    output dbp_pkg::dbp_lim_t lim_eff,
    output logic signed [15:0] torque_cmd
);
    if (LOOP_CYCLES < 2) begin : g_loop_chk
        $error("LOOP_CYCLES too small");
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [15:0] max_speed_q, max_speed_d;  // Trip speed
    logic [15:0] margin_q, margin_d;  // Braking band below trip
    logic [15:0] ov_cb_q, ov_cb_d;  // Over-voltage cutback
    logic [15:0] ov_lim_q, ov_lim_d;  // Over-voltage cut-out
    logic [15:0] uv_cb_q, uv_cb_d;  // Under-voltage cutback
    logic [15:0] uv_lim_q, uv_lim_d;  // Under-voltage cut-out
    logic [15:0] uv_delay_q, uv_delay_d;  // Delay in loop periods
    logic [7:0] cells_q, cells_d;  // Cell count
    logic [15:0] reset_v_q, reset_v_d;  // Per-cell reset voltage
    logic [6:0] warn_lvl_q, warn_lvl_d;  // Warning percent
    logic [6:0] cut_lvl_q, cut_lvl_d;  // Cut-out percent
    logic [15:0] rate_q, rate_d;  // Tenths of s per percent
    logic [7:0] mode_q, mode_d;  // Current limit mode
    logic torque_cb_en_q, torque_cb_en_d;  // Torque cutback enable
    logic [15:0] chg_lim_q, chg_lim_d;  // Charge limit magnitude
    logic [15:0] dis_lim_q, dis_lim_d;  // Discharge limit magnitude
    logic [7:0] prof_scale_q, prof_scale_d;  // Profile factor /256
    logic [15:0] pwr_chg_q, pwr_chg_d;  // Charge power limit
    logic [15:0] pwr_dis_q, pwr_dis_d;  // Discharge power limit

    // Register writes
    always_comb begin
        max_speed_d = max_speed_q;
        margin_d = margin_q;
        ov_cb_d = ov_cb_q;
        ov_lim_d = ov_lim_q;
        uv_cb_d = uv_cb_q;
        uv_lim_d = uv_lim_q;
        uv_delay_d = uv_delay_q;
        cells_d = cells_q;
        reset_v_d = reset_v_q;
        warn_lvl_d = warn_lvl_q;
        cut_lvl_d = cut_lvl_q;
        rate_d = rate_q;
        mode_d = mode_q;
        torque_cb_en_d = torque_cb_en_q;
        chg_lim_d = chg_lim_q;
        dis_lim_d = dis_lim_q;
        prof_scale_d = prof_scale_q;
        pwr_chg_d = pwr_chg_q;
        pwr_dis_d = pwr_dis_q;
        if (wr) begin
            case (addr)
                dbp_pkg::ADDR_MAX_SPEED: max_speed_d = wdata[15:0];
                dbp_pkg::ADDR_SPEED_MARGIN: margin_d = wdata[15:0];
                dbp_pkg::ADDR_OV_CUTBACK: ov_cb_d = wdata[15:0];
                dbp_pkg::ADDR_OV_LIMIT: ov_lim_d = wdata[15:0];
                dbp_pkg::ADDR_UV_CUTBACK: uv_cb_d = wdata[15:0];
                dbp_pkg::ADDR_UV_LIMIT: uv_lim_d = wdata[15:0];
                dbp_pkg::ADDR_UV_DELAY: uv_delay_d = wdata[15:0];
                dbp_pkg::ADDR_CELLS: cells_d = wdata[7:0];
                dbp_pkg::ADDR_RESET_V: reset_v_d = wdata[15:0];
                dbp_pkg::ADDR_GAUGE_LVL: begin
                    warn_lvl_d = wdata[6:0];
                    cut_lvl_d = wdata[14:8];
                end
                dbp_pkg::ADDR_RATE: rate_d = wdata[15:0];
                dbp_pkg::ADDR_CUR_MODE: begin
                    mode_d = wdata[7:0];
                    torque_cb_en_d = wdata[8];
                end
                dbp_pkg::ADDR_CUR_LIM: begin
                    chg_lim_d = wdata[15:0];
                    dis_lim_d = wdata[31:16];
                end
                dbp_pkg::ADDR_PROF_SCALE: prof_scale_d = wdata[7:0];
                dbp_pkg::ADDR_PWR_LIM: begin
                    pwr_chg_d = wdata[15:0];
                    pwr_dis_d = wdata[31:16];
                end
                default: ;
            endcase
        end
    end

    // Register storage; all-ones speed and over-voltage, zero under-voltage thresholds keep trips quiet until set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            max_speed_q <= 16'hFFFF;
            margin_q <= 16'h0000;
            ov_cb_q <= 16'hFFFF;
            ov_lim_q <= 16'hFFFF;
            uv_cb_q <= 16'h0000;
            uv_lim_q <= 16'h0000;
            uv_delay_q <= 16'h0000;
            cells_q <= 8'h00;
            reset_v_q <= 16'hFFFF;
            warn_lvl_q <= 7'h00;
            cut_lvl_q <= 7'h00;
            rate_q <= 16'h0000;
            mode_q <= 8'h00;
            torque_cb_en_q <= 1'b0;
            chg_lim_q <= 16'h0000;
            dis_lim_q <= 16'h0000;
            prof_scale_q <= 8'hFF;
            pwr_chg_q <= 16'h0000;
            pwr_dis_q <= 16'h0000;
        end else begin
            max_speed_q <= max_speed_d;
            margin_q <= margin_d;
            ov_cb_q <= ov_cb_d;
            ov_lim_q <= ov_lim_d;
            uv_cb_q <= uv_cb_d;
            uv_lim_q <= uv_lim_d;
            uv_delay_q <= uv_delay_d;
            cells_q <= cells_d;
            reset_v_q <= reset_v_d;
            warn_lvl_q <= warn_lvl_d;
            cut_lvl_q <= cut_lvl_d;
            rate_q <= rate_d;
            mode_q <= mode_d;
            torque_cb_en_q <= torque_cb_en_d;
            chg_lim_q <= chg_lim_d;
            dis_lim_q <= dis_lim_d;
            prof_scale_q <= prof_scale_d;
            pwr_chg_q <= pwr_chg_d;
            pwr_dis_q <= pwr_dis_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control-loop tick
    logic [31:0] loop_cnt_q, loop_cnt_d;  // Loop divider
    logic tick;  // One cycle per loop period
    assign tick = (loop_cnt_q == 32'(LOOP_CYCLES - 1));
    always_comb begin
        loop_cnt_d = tick ? 32'h0 : loop_cnt_q + 32'h1;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) loop_cnt_q <= 32'h0;
        else loop_cnt_q <= loop_cnt_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Protection state
    logic spd_flt_q, spd_flt_d;  // Over-speed fault
    logic ov_flt_q, ov_flt_d;  // Over-voltage fault
    logic uv_flt_q, uv_flt_d;  // Under-voltage fault
    logic brake_q, brake_d;  // Braking torque request
    logic [7:0] regen_q, regen_d;  // Regen scale /255
    logic [7:0] drive_q, drive_d;  // Drive scale /255
    logic [15:0] uv_cnt_q, uv_cnt_d;  // Under-voltage timer
    logic [15:0] ov_ex, uv_ex;  // Voltage excess beyond cutback

    // Threshold compare, only on each tick
    always_comb begin
        spd_flt_d = spd_flt_q;
        ov_flt_d = ov_flt_q;
        uv_flt_d = uv_flt_q;
        brake_d = brake_q;
        regen_d = regen_q;
        drive_d = drive_q;
        uv_cnt_d = uv_cnt_q;
        ov_ex = meas.volts - ov_cb_q;
        uv_ex = uv_cb_q - meas.volts;
        if (tick) begin
            brake_d = (meas.speed >= max_speed_q - margin_q);
            if (meas.speed > max_speed_q) spd_flt_d = 1'b1;
            regen_d = 8'hFF;
            if (meas.volts > ov_cb_q) regen_d = (ov_ex > 16'h00FF) ? 8'h00 : 8'hFF - ov_ex[7:0];
            if (meas.volts > ov_lim_q) ov_flt_d = 1'b1;
            drive_d = 8'hFF;
            if (meas.volts < uv_cb_q) drive_d = (uv_ex > 16'h00FF) ? 8'h00 : 8'hFF - uv_ex[7:0];
            if (meas.volts < uv_lim_q) begin
                if (uv_cnt_q >= uv_delay_q) uv_flt_d = 1'b1;
                else uv_cnt_d = uv_cnt_q + 16'h1;
            end else begin
                uv_cnt_d = 16'h0;
            end
        end
    end

    // Faults latch until reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spd_flt_q <= 1'b0;
            ov_flt_q <= 1'b0;
            uv_flt_q <= 1'b0;
            brake_q <= 1'b0;
            regen_q <= 8'hFF;
            drive_q <= 8'hFF;
            uv_cnt_q <= 16'h0;
        end else begin
            spd_flt_q <= spd_flt_d;
            ov_flt_q <= ov_flt_d;
            uv_flt_q <= uv_flt_d;
            brake_q <= brake_d;
            regen_q <= regen_d;
            drive_q <= drive_d;
            uv_cnt_q <= uv_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Charge gauge
    logic [6:0] gauge_q, gauge_d;  // Remaining charge percent
    logic [15:0] g_tmr_q, g_tmr_d;  // Loop periods into interval
    logic [15:0] interval;  // Loops per percent
    logic gauge_en;  // Gauge enabled
    logic [23:0] cell_v;  // Full-charge pack voltage
    assign gauge_en = (cells_q != 8'h00);
    assign cell_v = 24'(reset_v_q) * 24'(cells_q);
    assign interval = 16'(((rate_q == 16'h0) ? 32'(dbp_pkg::RATE_DEF_DS) : 32'(rate_q))
                          * 100 / dbp_pkg::MS_PER_LOOP);

    // Gauge update once per loop; held full every cycle while disabled
    always_comb begin
        gauge_d = gauge_q;
        g_tmr_d = g_tmr_q;
        if (!gauge_en) begin
            gauge_d = dbp_pkg::GAUGE_FULL;
            g_tmr_d = 16'h0;
        end else if (tick) begin
            if (24'(meas.volts) >= cell_v) begin
                gauge_d = dbp_pkg::GAUGE_FULL;
                g_tmr_d = 16'h0;
            end else if (g_tmr_q + 16'h1 >= interval) begin
                g_tmr_d = 16'h0;
                if (gauge_q != 7'h00) gauge_d = gauge_q - 7'h1;
            end else begin
                g_tmr_d = g_tmr_q + 16'h1;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gauge_q <= dbp_pkg::GAUGE_FULL;
            g_tmr_q <= 16'h0;
        end else begin
            gauge_q <= gauge_d;
            g_tmr_q <= g_tmr_d;
        end
    end
    // Low-battery actions, zero level disables
    assign low_battery_profile = gauge_en && (cut_lvl_q != 7'h00) && (gauge_q <= cut_lvl_q);
    assign low_charge_warn = gauge_en && (warn_lvl_q != 7'h00) && (gauge_q <= warn_lvl_q);

    ////////////////////////////////////////////////////////////////////////
    // Battery current limits
    dbp_pkg::dbp_lim_t lim_q, lim_d;  // Limits in effect
    logic signed [15:0] tq_q, tq_d;  // Torque command
    logic [31:0] pwr_div_c, pwr_div_d;  // Power to current
    logic [23:0] dis_sc;  // Profile-scaled discharge
    logic [15:0] volts_nz;  // Divide guard
    assign volts_nz = (meas.volts == 16'h0) ? 16'h1 : meas.volts;
    assign pwr_div_c = {16'h0, pwr_chg_q} / {16'h0, volts_nz};
    assign pwr_div_d = {16'h0, pwr_dis_q} / {16'h0, volts_nz};
    assign dis_sc = 24'(dis_lim_q) * 24'(prof_scale_q);

    // Select limit source; charge limit negative
    always_comb begin
        lim_d = lim_q;
        tq_d = tq_q;
        if (tick) begin
            case (mode_q)
                dbp_pkg::MODE_OFF: begin
                    if (chg_lim_q == 16'h0 && dis_lim_q == 16'h0) begin
                        lim_d.charge = -$signed(dbp_pkg::LIMIT_MAX);
                        lim_d.discharge = $signed(dbp_pkg::LIMIT_MAX);
                    end else begin
                        lim_d.charge = -$signed({1'b0, chg_lim_q[14:0]});
                        lim_d.discharge = $signed({1'b0, dis_lim_q[14:0]});
                    end
                end
                dbp_pkg::MODE_FIXED: begin
                    lim_d.charge = -$signed({1'b0, chg_lim_q[14:0]});
                    lim_d.discharge = $signed({1'b0, dis_lim_q[14:0]});
                end
                dbp_pkg::MODE_BMS: lim_d = bms_lim;
                dbp_pkg::MODE_PROFILE: begin
                    lim_d.charge = -$signed({1'b0, chg_lim_q[14:0]});
                    lim_d.discharge = profile_active ? $signed({1'b0, dis_sc[22:8]})
                                                     : $signed({1'b0, dis_lim_q[14:0]});
                end
                dbp_pkg::MODE_POWER: begin
                    lim_d.charge = -$signed({1'b0, pwr_div_c[14:0]});
                    lim_d.discharge = $signed({1'b0, pwr_div_d[14:0]});
                end
                default: ;
            endcase
            tq_d = torque_req;
            if (torque_cb_en_q) begin
                if (torque_req > lim_q.discharge) tq_d = lim_q.discharge;
                else if (torque_req < lim_q.charge) tq_d = lim_q.charge;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lim_q <= '0;
            tq_q <= 16'sh0;
        end else begin
            lim_q <= lim_d;
            tq_q <= tq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    logic [31:0] rdata_q, rdata_d;
    always_comb begin
        rdata_d = 32'h0;
        if (rd) begin
            case (addr)
                dbp_pkg::ADDR_MAX_SPEED: rdata_d = {16'h0, max_speed_q};
                dbp_pkg::ADDR_OV_LIMIT: rdata_d = {16'h0, ov_lim_q};
                dbp_pkg::ADDR_UV_LIMIT: rdata_d = {16'h0, uv_lim_q};
                dbp_pkg::ADDR_CELLS: rdata_d = {24'h0, cells_q};
                dbp_pkg::ADDR_CUR_MODE: rdata_d = {23'h0, torque_cb_en_q, mode_q};
                dbp_pkg::ADDR_STATUS: rdata_d = {26'h0, 1'b0, low_charge_warn,
                    low_battery_profile, uv_flt_q, ov_flt_q, spd_flt_q};
                dbp_pkg::ADDR_GAUGE: rdata_d = {25'h0, gauge_q};
                dbp_pkg::ADDR_LIM_EFF: rdata_d = lim_q;
                default: rdata_d = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rdata_q <= 32'h0;
        else rdata_q <= rdata_d;
    end

    // Outputs
    assign rdata = rdata_q;
    assign power_enable = !(spd_flt_q || ov_flt_q || uv_flt_q);
    assign brake_request = brake_q;
    assign regen_scale = regen_q;
    assign drive_scale = drive_q;
    assign charge_gauge = gauge_q;
    assign lim_eff = lim_q;
    assign torque_cmd = tq_q;
endmodule
`default_nettype wire

// *** src/dbp_pkg.sv ***
// Package for the drive and battery protection block: constants, types.
// Assumes a single 40 MHz clock and a plain register port.
`default_nettype none
package dbp_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_MAX_SPEED = 8'h00;
    localparam logic [7:0] ADDR_SPEED_MARGIN = 8'h04;
    localparam logic [7:0] ADDR_OV_CUTBACK = 8'h08;
    localparam logic [7:0] ADDR_OV_LIMIT = 8'h0C;
    localparam logic [7:0] ADDR_UV_CUTBACK = 8'h10;
    localparam logic [7:0] ADDR_UV_LIMIT = 8'h14;
    localparam logic [7:0] ADDR_UV_DELAY = 8'h18;
    localparam logic [7:0] ADDR_CELLS = 8'h1C;
    localparam logic [7:0] ADDR_RESET_V = 8'h20;
    localparam logic [7:0] ADDR_GAUGE_LVL = 8'h24;
    localparam logic [7:0] ADDR_RATE = 8'h28;
    localparam logic [7:0] ADDR_CUR_MODE = 8'h2C;
    localparam logic [7:0] ADDR_CUR_LIM = 8'h30;
    localparam logic [7:0] ADDR_PROF_SCALE = 8'h34;
    localparam logic [7:0] ADDR_PWR_LIM = 8'h38;
    localparam logic [7:0] ADDR_STATUS = 8'h3C;
    localparam logic [7:0] ADDR_GAUGE = 8'h40;
    localparam logic [7:0] ADDR_LIM_EFF = 8'h44;
    // Current limit modes
    localparam logic [7:0] MODE_OFF = 8'h00;
    localparam logic [7:0] MODE_FIXED = 8'h01;
    localparam logic [7:0] MODE_BMS = 8'h02;
    localparam logic [7:0] MODE_PROFILE = 8'h03;
    localparam logic [7:0] MODE_POWER = 8'h04;
    // Reset and default values
    localparam logic [6:0] GAUGE_FULL = 7'h64;
    localparam logic [15:0] LIMIT_MAX = 16'h7FFF;
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int LOOP_US = 1000;
    localparam int LOOP_CYC = LOOP_US * (CLK_HZ / 1_000_000);
    localparam int RATE_DEF_DS = 168;
    localparam int MS_PER_LOOP = LOOP_US / 1000;
    // Status bits
    localparam int ST_SPEED_FLT = 0;
    localparam int ST_OV_FLT = 1;
    localparam int ST_UV_FLT = 2;
    localparam int ST_LOW_BATT = 3;
    localparam int ST_WARN = 4;
    localparam int ST_CUT = 5;
    // Measurement bundle
    typedef struct packed {
        logic [15:0] speed;
        logic [15:0] volts;
        logic signed [15:0] current;
    } dbp_meas_t;
    // Limits, signed: charge is negative
    typedef struct packed {
        logic signed [15:0] charge;
        logic signed [15:0] discharge;
    } dbp_lim_t;
endpackage
`default_nettype wire

// *** testbench/dbp_protect_chk.sv ***
// Checker: timing and range relations at the block's ports.
// Assumes the loop counter restarts at zero on reset.
`default_nettype none
module dbp_protect_chk #(
    parameter int LOOP_CYCLES = dbp_pkg::LOOP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // Protection outputs
    input wire logic power_enable,
    input wire logic brake_request,
    input wire logic [7:0] regen_scale,
    input wire logic [7:0] drive_scale,
    input wire logic [6:0] charge_gauge,
    input wire dbp_pkg::dbp_lim_t lim_eff
);
    ////////////////////////////////////////////////////////////////////////
    // Shadow loop counter
    logic [31:0] cnt_q, cnt_d; // Cycle within loop
    logic tick; // Last cycle of loop
    assign tick = (cnt_q == 32'(LOOP_CYCLES - 1));
    // Wrap at loop end
    always_comb begin
        cnt_d = tick ? 32'h0 : cnt_q + 32'h1;
    end
    // Register only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cnt_q <= 32'h0;
        else cnt_q <= cnt_d;
    end
    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("rdata not idle");
    chk_rdata_unmap: assert property (rd && addr >= 8'h48 |=> rdata == 32'h0)
        else $error("unmapped rdata");
    chk_fault_hold: assert property (!power_enable |=> !power_enable)
        else $error("fault released");
    chk_fault_tick: assert property ($fell(power_enable) |-> $past(tick))
        else $error("cut off tick");
    chk_scale_tick: assert property ($changed(regen_scale) || $changed(drive_scale) || $changed(brake_request)
        |-> $past(tick))
        else $error("scale off tick");
    chk_gauge_tick: assert property ($changed(charge_gauge) |-> $past(tick))
        else $error("gauge off tick");
    chk_gauge_step: assert property ($changed(charge_gauge)
        |-> charge_gauge == $past(charge_gauge) - 7'h01 || charge_gauge == 7'h64)
        else $error("gauge step");
    chk_gauge_range: assert property (charge_gauge <= 7'h64)
        else $error("gauge above full");
    chk_lim_sign: assert property (lim_eff.charge <= 16'sh0000 && lim_eff.discharge >= 16'sh0000)
        else $error("limit sign");
endmodule
bind dbp_protect dbp_protect_chk #(.LOOP_CYCLES(LOOP_CYCLES)) u_chk (.clk(clk), .rst(rst), .addr(addr),
    .rd(rd), .rdata(rdata), .power_enable(power_enable), .brake_request(brake_request),
    .regen_scale(regen_scale), .drive_scale(drive_scale), .charge_gauge(charge_gauge), .lim_eff(lim_eff));
`default_nettype wire

// *** testbench/dbp_plant.sv ***
// Battery, motor and BMS model: registered measurements.
// Assumes set values change on rising edges.
`default_nettype none
module dbp_plant (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Set values
    input wire logic [15:0] speed_set,
    input wire logic [15:0] volts_set,
    input wire dbp_pkg::dbp_lim_t bms_set,
    input wire logic brake_request,
    // Measured values
    output var dbp_pkg::dbp_meas_t meas,
    output var dbp_pkg::dbp_lim_t bms_lim
);
    // Sensor chain, one cycle late; regen current negative
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meas <= '0;
            bms_lim <= '0;
        end else begin
            meas <= '{speed_set, volts_set, brake_request ? -16'sd100 : 16'sd200};
            bms_lim <= bms_set;
        end
    end
endmodule
`default_nettype wire

// *** testbench/test_dbp_protect.sv ***
// Bench: limit modes by table, then protections and gauge.
// Assumes a short loop through LOOP_CYCLES.
`default_nettype none
module test_dbp_protect;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LP = 10;
    typedef struct packed {logic [8:0] mode; logic [31:0] lim; logic prof; logic [31:0] exp;} dbp_row_t;
    // Mode rows: mode, limits {dis,chg}, profile, expected {charge,discharge}
    localparam dbp_row_t ROWS[7] = '{
        '{9'h0, 32'h0, 1'b0, 32'h8001_7FFF},
        '{9'h0, 32'h03E8_01F4, 1'b0, 32'hFE0C_03E8},
        '{9'h1, 32'h03E8_01F4, 1'b0, 32'hFE0C_03E8},
        '{9'h2, 32'h03E8_01F4, 1'b0, 32'hFC18_07D0},
        '{9'h3, 32'h03E8_01F4, 1'b0, 32'hFE0C_03E8},
        '{9'h3, 32'h03E8_01F4, 1'b1, 32'hFE0C_01F4},
        '{9'h4, 32'h03E8_01F4, 1'b0, 32'h0000_03E8}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [15:0] speed_set = 16'h0;
    logic [15:0] volts_set = 16'h0030;
    dbp_pkg::dbp_lim_t bms_set = 32'hFC18_07D0;
    dbp_pkg::dbp_meas_t meas;
    dbp_pkg::dbp_lim_t bms_lim;
    logic profile_active = 1'b0;
    logic signed [15:0] torque_req = 16'sh0;
    logic power_enable, brake_request, low_battery_profile, low_charge_warn;
    logic [7:0] regen_scale, drive_scale;
    logic [6:0] charge_gauge;
    dbp_pkg::dbp_lim_t lim_eff;
    logic signed [15:0] torque_cmd;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    always #12.5 clk = ~clk;
    dbp_plant plant (.clk(clk), .rst(rst), .speed_set(speed_set), .volts_set(volts_set), .bms_set(bms_set),
        .brake_request(brake_request), .meas(meas), .bms_lim(bms_lim));
    dbp_protect #(.LOOP_CYCLES(LP)) uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .meas(meas), .bms_lim(bms_lim), .profile_active(profile_active), .torque_req(torque_req),
        .power_enable(power_enable), .brake_request(brake_request), .regen_scale(regen_scale),
        .drive_scale(drive_scale), .low_battery_profile(low_battery_profile), .low_charge_warn(low_charge_warn),
        .charge_gauge(charge_gauge), .lim_eff(lim_eff), .torque_cmd(torque_cmd));
    ////////////////////////////////////////////////////////////////////////
    // Verdict and run guard
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Compare and drive tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask
    task automatic ticks(input int t);
        repeat (t * LP) @(posedge clk);
        #1;
    endtask
    task automatic set_meas(input logic [15:0] s, input logic [15:0] v);
        @(posedge clk); speed_set <= s; volts_set <= v;
    endtask
    task automatic do_reset;
        @(posedge clk); rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
    endtask
    // Cycles until the gauge moves, bounded
    task automatic wait_gauge(output int c);
        logic [6:0] g;
        g = charge_gauge;
        c = 0;
        while (charge_gauge === g && c < 110 * LP) begin
            @(posedge clk); #1; c++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1 chk("power_enable", 32'h1, power_enable);
        chk("regen_scale", 32'hFF, regen_scale);
        chk("charge_gauge", 32'h64, charge_gauge);
        wr_reg(dbp_pkg::ADDR_PROF_SCALE, 32'h80);
        wr_reg(dbp_pkg::ADDR_PWR_LIM, 32'hBB80_0000);
        rd_chk("unmapped", 8'h48, 32'h0);
        rd_chk("write_only", dbp_pkg::ADDR_PROF_SCALE, 32'h0);
        foreach (ROWS[i]) begin
            wr_reg(dbp_pkg::ADDR_CUR_MODE, {23'h0, ROWS[i].mode});
            wr_reg(dbp_pkg::ADDR_CUR_LIM, ROWS[i].lim);
            @(posedge clk); profile_active <= ROWS[i].prof;
            ticks(3);
            chk("lim_eff", ROWS[i].exp, lim_eff);
        end
        rd_chk("cur_mode", dbp_pkg::ADDR_CUR_MODE, 32'h4);
        // Torque clamped to the limits, then passed through with cutback off
        wr_reg(dbp_pkg::ADDR_CUR_MODE, 32'h101);
        @(posedge clk); torque_req <= 16'sh07D0;
        ticks(3); chk("torque_cmd", 32'h03E8, 32'(torque_cmd));
        @(posedge clk); torque_req <= 16'shF830;
        ticks(3); chk("torque_cmd", 32'hFFFF_FE0C, 32'(torque_cmd));
        wr_reg(dbp_pkg::ADDR_CUR_MODE, 32'h001);
        ticks(3); chk("torque_cmd", 32'hFFFF_F830, 32'(torque_cmd));
        // Speed: brake, trip, stay tripped
        wr_reg(dbp_pkg::ADDR_MAX_SPEED, 32'h03E8);
        wr_reg(dbp_pkg::ADDR_SPEED_MARGIN, 32'h0064);
        set_meas(16'd950, 16'd48); ticks(2);
        chk("brake_request", 32'h1, brake_request);
        chk("power_enable", 32'h1, power_enable);
        set_meas(16'd1001, 16'd48); ticks(2);
        chk("power_enable", 32'h0, power_enable);
        set_meas(16'd0, 16'd48); ticks(2);
        chk("power_enable", 32'h0, power_enable);
        rd_chk("status", dbp_pkg::ADDR_STATUS, 32'h1);
        do_reset();
        chk("power_enable", 32'h1, power_enable);
        // Over-voltage cutback then cut-out
        wr_reg(dbp_pkg::ADDR_OV_CUTBACK, 32'h32);
        wr_reg(dbp_pkg::ADDR_OV_LIMIT, 32'h3C);
        set_meas(16'd0, 16'd55); ticks(2);
        chk("regen_scale", 32'hFA, regen_scale);
        set_meas(16'd0, 16'd61); ticks(2);
        chk("power_enable", 32'h0, power_enable);
        rd_chk("status", dbp_pkg::ADDR_STATUS, 32'h2);
        do_reset();
        // Under-voltage: cutback, timer restart, cut-out
        wr_reg(dbp_pkg::ADDR_UV_CUTBACK, 32'h28);
        wr_reg(dbp_pkg::ADDR_UV_LIMIT, 32'h1E);
        wr_reg(dbp_pkg::ADDR_UV_DELAY, 32'h3);
        set_meas(16'd0, 16'd35); ticks(2);
        chk("drive_scale", 32'hFA, drive_scale);
        set_meas(16'd0, 16'd29);
        repeat (3 * LP - 3) @(posedge clk);
        set_meas(16'd0, 16'd31); ticks(2);
        chk("power_enable", 32'h1, power_enable);
        set_meas(16'd0, 16'd29); ticks(2);
        chk("power_enable", 32'h1, power_enable);
        ticks(6); chk("power_enable", 32'h0, power_enable);
        rd_chk("status", dbp_pkg::ADDR_STATUS, 32'h4);
        do_reset();
        // Gauge: off, steps, low profile, refill
        wr_reg(dbp_pkg::ADDR_RATE, 32'h1);
        wr_reg(dbp_pkg::ADDR_GAUGE_LVL, 32'h6300);
        wr_reg(dbp_pkg::ADDR_RESET_V, 32'h2);
        set_meas(16'd0, 16'd40); ticks(120);
        chk("charge_gauge", 32'h64, charge_gauge);
        chk("low_battery_profile", 32'h0, low_battery_profile);
        wr_reg(dbp_pkg::ADDR_CELLS, 32'h18);
        wait_gauge(n);
        chk("charge_gauge", 32'h63, charge_gauge);
        chk("low_battery_profile", 32'h1, low_battery_profile);
        chk("low_charge_warn", 32'h0, low_charge_warn);
        wait_gauge(n);
        chk("interval", 32'(100 * LP), 32'(n));
        set_meas(16'd0, 16'd48); ticks(2);
        chk("charge_gauge", 32'h64, charge_gauge);
        rd_chk("gauge", dbp_pkg::ADDR_GAUGE, 32'h64);
        end_sim();
    end
endmodule
`default_nettype wire
